// ---- rtl/pmtb_pkg.sv ----
// package: register map, field layout, reset values and timing of the master time bases
package pmtb_pkg;

  // register byte offsets (one aligned 32-bit word each)
  localparam logic [4:0] OFF_PRI_CLK_DIV  = 5'h00;  // primary_clock_divider
  localparam logic [4:0] OFF_PRI_PERIOD   = 5'h04;  // primary_period
  localparam logic [4:0] OFF_SEV_COMPARE  = 5'h08;  // special_event_compare
  localparam logic [4:0] OFF_SEC_CONTROL  = 5'h0C;  // secondary_base_control
  localparam logic [4:0] OFF_SEC_CLK_DIV  = 5'h10;  // secondary_clock_divider
  localparam logic [4:0] OFF_SEC_PERIOD   = 5'h14;  // secondary_period
  localparam logic [4:0] OFF_MOD_ENABLE   = 5'h18;  // module_enable control
  localparam logic [4:0] OFF_TIMER_STATUS = 5'h1C;  // live secondary counter value

  // secondary_base_control field positions
  localparam int unsigned POS_SEV_PENDING = 12;  // special_event_pending
  localparam int unsigned POS_SEV_IRQ_EN  = 11;  // special_event_irq_enable
  localparam int unsigned POS_IMM_UPDATE  = 10;  // immediate_period_update
  localparam int unsigned POS_SYNC_POL    = 9;   // sync_polarity
  localparam int unsigned POS_SYNC_OEN    = 8;   // sync_output_enable
  localparam int unsigned POS_EXT_SYNC_EN = 7;   // external_sync_enable
  localparam int unsigned POS_SYNC_SRC    = 4;   // sync_source_select low bit
  localparam int unsigned POS_POSTSCALE   = 0;   // special_event_postscale low bit

  // reset values
  localparam logic [15:0] RST_PERIOD   = 16'hFFF8;  // bits 15..3 set, 2..0 clear
  localparam logic [15:0] RST_COMPARE  = 16'h0000;
  localparam logic [2:0]  RST_PRESCALE = 3'h0;      // divide by 1
  localparam logic [11:0] RST_CONTROL  = 12'h000;   // writable control bits 11..0

  // masks
  localparam logic [15:0] MASK_COMPARE = 16'hFFF8;  // low three bits unimplemented

  // bus answer timing: waitrequest low one cycle after the request is seen
  localparam int unsigned BUS_WAIT_CYCLES = 1;

  // prescaler codes
  localparam logic [2:0] PRESCALE_MAX = 3'h6;  // divide by 64; 3'h7 reserved

  // fsm for the bus slave handshake
  typedef enum logic [1:0] {
    PMTB_BUS_IDLE = 2'b00,
    PMTB_BUS_ACK  = 2'b01
  } pmtb_bus_state_e;

endpackage

// ---- rtl/pmtb_prescaler.sv ----
// module: input clock prescaler producing a one-cycle tick every 2**code clocks, every 64 for reserved code 7
`timescale 1ns/1ps
module pmtb_prescaler
  import pmtb_pkg::*;
(
  input  wire logic       ref_clk_i,   // system clock
  input  wire logic       sys_rst_i,   // synchronous reset, active high
  input  wire logic       run_i,       // counting allowed (module enabled)
  input  wire logic [2:0] prescale_i,  // input_clock_prescale code
  output logic            tick_o       // one-cycle advance pulse
);

  logic [5:0] div_cnt;  // free divider counter

  // limit of the divider: 2**code - 1; reserved code 7 behaves as divide by 64
  function automatic logic [5:0] div_limit(input logic [2:0] code);
    logic [2:0] c;
    c = (code > PRESCALE_MAX) ? PRESCALE_MAX : code;
    div_limit = 6'((7'h01 << c) - 7'h01);
  endfunction

  // divider counter; held at zero while disabled so restart is aligned
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      div_cnt <= 6'h00;
    end else if (div_cnt >= div_limit(prescale_i)) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  assign tick_o = run_i && (div_cnt >= div_limit(prescale_i));

  // divide by 1 ticks every cycle while running
  property p_div1_every_cycle;
    @(posedge ref_clk_i) disable iff (sys_rst_i) (run_i && prescale_i == 3'h0) |-> tick_o;
  endproperty
  a_div1_every_cycle: assert property (p_div1_every_cycle)
    else $error("divide by one did not tick every cycle");
  // divide by 2 never ticks twice in a row under a stable setting
  property p_div2_spacing;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (tick_o && prescale_i == 3'h1 && $stable(prescale_i)) ##1 (run_i && prescale_i == 3'h1) |-> !tick_o;
  endproperty
  a_div2_spacing: assert property (p_div2_spacing)
    else $error("divide by two ticked on adjacent cycles");

endmodule

// ---- rtl/pmtb_postscaler.sv ----
// module: special event postscaler, one trigger per N compare matches
`timescale 1ns/1ps
module pmtb_postscaler
  import pmtb_pkg::*;
(
  input  wire logic       ref_clk_i,   // system clock
  input  wire logic       sys_rst_i,   // synchronous reset, active high
  input  wire logic       run_i,       // module enabled
  input  wire logic [3:0] ratio_i,     // special_event_postscale code, N = code + 1
  input  wire logic       match_i,     // compare match pulse
  output logic            trigger_o    // postscaled special event pulse
);

  logic [3:0] match_cnt;  // matches seen since last trigger

  // count matches; the count wraps after code+1 of them
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      match_cnt <= 4'h0;
    end else if (match_i) begin
      match_cnt <= (match_cnt >= ratio_i) ? 4'h0 : match_cnt + 4'h1;
    end
  end

  // trigger on the Nth match; at 1:1 every match fires
  assign trigger_o = match_i && run_i && (match_cnt >= ratio_i);

  // at ratio code zero every match must fire
  property p_one_to_one;
    @(posedge ref_clk_i) disable iff (sys_rst_i) (match_i && run_i && ratio_i == 4'h0) |-> trigger_o;
  endproperty
  a_one_to_one: assert property (p_one_to_one)
    else $error("ratio 1:1 missed a trigger");
  // a trigger only ever accompanies a match
  property p_no_trigger_without_match;
    @(posedge ref_clk_i) disable iff (sys_rst_i) trigger_o |-> match_i;
  endproperty
  a_no_trigger_without_match: assert property (p_no_trigger_without_match)
    else $error("trigger without a compare match");

endmodule

// ---- rtl/pmtb_time_base.sv ----
// module: primary and secondary master time bases with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - prescaler codes 0..6 divide by 1..64
// - compare stores bits 15..3, low reads zero
// - pending bit 12 set and cleared by hardware
// - immediate update bit selects secondary period loading
// - polarity bit inverts sync input and output
// - sync output driven only when enabled
// - external sync enable gates selected input
// - source field selects sync inputs one..four
// - postscale ratio code plus one
// - secondary period 16 bits, resets 0xFFF8
// - primary period 16 bits, resets 0xFFF8
// - immediate update touches secondary period only
// - divider registers bits 15..3 read zero
// - module enable turns counters and events on/off; registers and sync output enable stay live
// - postscaler triggers once per N matches
module pmtb_time_base
  import pmtb_pkg::*;
#(
  parameter int unsigned SYNC_INPUTS = 4  // number of external sync inputs
) (
  input  wire logic                   ref_clk_i,             // system clock, 100 MHz
  input  wire logic                   sys_rst_i,             // synchronous reset, active high
  // avalon-mm slave
  input  wire logic [4:0]             avs_address_i,         // byte address
  input  wire logic                   avs_read_i,            // read request
  input  wire logic                   avs_write_i,           // write request
  input  wire logic [31:0]            avs_writedata_i,       // write data
  input  wire logic [3:0]             avs_byteenable_i,      // byte lanes
  output logic [31:0]                 avs_readdata_o,        // read data
  output logic                        avs_waitrequest_o,     // stall
  output logic [1:0]                  avs_response_o,        // 00 okay, 10 slave error
  // link side
  input  wire logic [SYNC_INPUTS-1:0] external_sync_input_i, // external sync pins
  output logic                        secondary_sync_output_o,    // sync pulse level
  output logic                        secondary_sync_output_oe_o, // output driver enable
  output logic                        special_event_trigger_o,    // primary postscaled trigger
  output logic                        secondary_irq_o,            // secondary event request
  output logic [15:0]                 primary_master_timer_o,     // live primary count
  output logic [15:0]                 secondary_master_timer_o    // live secondary count
);

  // the source field decodes exactly four inputs; refuse any other count
  if (SYNC_INPUTS != 4) begin : g_bad_sync_inputs
    $error("SYNC_INPUTS must be 4");
  end

  // software-visible state
  logic [2:0]  pri_prescale;      // primary input_clock_prescale
  logic [2:0]  sec_prescale;      // secondary input_clock_prescale
  logic [15:0] primary_period;    // primary period, also active (no buffering asked)
  logic [15:0] sev_compare;       // special event compare, low bits held zero
  logic [11:0] sec_ctrl;          // secondary control bits 11..0
  logic        sev_pending;       // special_event_pending, hardware owned
  logic        module_enable;     // unit on/off
  logic [15:0] sec_period_buf;    // secondary period as written
  logic [15:0] sec_period_act;    // secondary period in use
  // time base state
  logic [15:0] pri_cnt;           // primary_master_timer
  logic [15:0] sec_cnt;           // secondary_master_timer
  logic        pri_tick;          // primary advance
  logic        sec_tick;          // secondary advance
  logic        sec_wrap;          // secondary cycle boundary
  logic        sync_raw;          // selected external input, raw level
  logic        sync_act;          // selected input, polarity corrected
  logic        sync_act_d;        // previous corrected level for edge find
  logic        sync_rise;         // enabled external sync edge
  logic        sec_match;         // secondary compare match (against primary compare)
  logic        sec_trigger;       // postscaled secondary event
  logic        pri_match;         // primary compare match
  // bus
  pmtb_bus_state_e bus_state;     // handshake state
  logic        wr_en;             // accepted write, one cycle
  logic        mapped;            // address decodes to a register
  logic [15:0] rd_word;           // selected read value
  logic [15:0] wdata;             // low 16 bits of writedata, byte lanes ignored
  logic [15:0] wr_low;            // write data merged onto zero, for narrow registers

  // control field views
  wire       f_irq_en   = sec_ctrl[POS_SEV_IRQ_EN];
  wire       f_imm_upd  = sec_ctrl[POS_IMM_UPDATE];
  wire       f_sync_pol = sec_ctrl[POS_SYNC_POL];
  wire       f_sync_oen = sec_ctrl[POS_SYNC_OEN];
  wire       f_ext_en   = sec_ctrl[POS_EXT_SYNC_EN];
  wire [2:0] f_src      = sec_ctrl[POS_SYNC_SRC +: 3];
  wire [3:0] f_post     = sec_ctrl[POS_POSTSCALE +: 4];

  // merge byte lanes of a write onto the current 16-bit value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus handshake: request is answered one cycle after it is seen
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bus_state <= PMTB_BUS_IDLE;
    end else begin
      case (bus_state)
        PMTB_BUS_IDLE: bus_state <= (avs_read_i || avs_write_i) ? PMTB_BUS_ACK : PMTB_BUS_IDLE;
        PMTB_BUS_ACK:  bus_state <= PMTB_BUS_IDLE;  // master releases at this edge
        default:       bus_state <= PMTB_BUS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_state != PMTB_BUS_ACK);
  assign wr_en  = avs_write_i && (bus_state == PMTB_BUS_ACK);
  assign wdata  = avs_writedata_i[15:0];
  assign wr_low = merge(16'h0000, avs_writedata_i, avs_byteenable_i);

  // address decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_word = 16'h0000;
    case (avs_address_i)
      OFF_PRI_CLK_DIV:  rd_word = {13'h0, pri_prescale};
      OFF_PRI_PERIOD:   rd_word = primary_period;
      OFF_SEV_COMPARE:  rd_word = sev_compare & MASK_COMPARE;
      OFF_SEC_CONTROL:  rd_word = {3'h0, sev_pending, sec_ctrl};
      OFF_SEC_CLK_DIV:  rd_word = {13'h0, sec_prescale};
      OFF_SEC_PERIOD:   rd_word = sec_period_buf;
      OFF_MOD_ENABLE:   rd_word = {15'h0, module_enable};
      OFF_TIMER_STATUS: rd_word = sec_cnt;
      default:          mapped  = 1'b0;
    endcase
  end

  // read data and response registered; stand at the acknowledge edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if ((avs_read_i || avs_write_i) && bus_state == PMTB_BUS_IDLE) begin
      avs_readdata_o <= avs_read_i ? {16'h0000, rd_word} : 32'h0000_0000;
      avs_response_o <= mapped ? 2'h0 : 2'h2;
    end
  end

  // configuration registers; prescaler writes accepted only while disabled
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pri_prescale   <= RST_PRESCALE;
      sec_prescale   <= RST_PRESCALE;
      primary_period <= RST_PERIOD;
      sev_compare    <= RST_COMPARE;
      sec_ctrl       <= RST_CONTROL;
      module_enable  <= 1'b0;
      sec_period_buf <= RST_PERIOD;
    end else if (wr_en) begin
      case (avs_address_i)
        // changing division while running is unpredictable; guard it here
        OFF_PRI_CLK_DIV: if (!module_enable) pri_prescale <= wr_low[2:0];
        OFF_SEC_CLK_DIV: if (!module_enable) sec_prescale <= wr_low[2:0];
        OFF_PRI_PERIOD:  primary_period <= merge(primary_period, avs_writedata_i, avs_byteenable_i);
        OFF_SEV_COMPARE: sev_compare <= merge(sev_compare, avs_writedata_i, avs_byteenable_i) & MASK_COMPARE;
        OFF_SEC_CONTROL: sec_ctrl <= 12'(merge({4'h0, sec_ctrl}, avs_writedata_i, avs_byteenable_i));
        OFF_SEC_PERIOD:  sec_period_buf <= merge(sec_period_buf, avs_writedata_i, avs_byteenable_i);
        OFF_MOD_ENABLE:  if (avs_byteenable_i[0]) module_enable <= wdata[0];
        default: ;
      endcase
    end
  end

  // prescalers for both bases
  pmtb_prescaler u_pri_pre (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (module_enable),
    .prescale_i (pri_prescale),
    .tick_o     (pri_tick)
  );
  pmtb_prescaler u_sec_pre (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (module_enable),
    .prescale_i (sec_prescale),
    .tick_o     (sec_tick)
  );

  // external sync selection; reserved codes select nothing
  always_comb begin
    sync_raw = 1'b0;
    if (f_src < 3'h4) sync_raw = external_sync_input_i[f_src[1:0]];
  end
  assign sync_act  = sync_raw ^ f_sync_pol;
  assign sync_rise = module_enable && f_ext_en && sync_act && !sync_act_d;

  // edge memory for the corrected sync level
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) sync_act_d <= 1'b0;
    else           sync_act_d <= sync_act;
  end

  // primary counter: advance per tick, wrap at the period
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !module_enable) begin
      pri_cnt <= 16'h0000;
    end else if (pri_tick) begin
      pri_cnt <= (pri_cnt >= primary_period) ? 16'h0000 : pri_cnt + 16'h0001;
    end
  end

  // secondary counter: wraps at active period or on an enabled sync edge
  assign sec_wrap = sec_tick && (sec_cnt >= sec_period_act);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !module_enable) begin
      sec_cnt <= 16'h0000;
    end else if (sync_rise) begin
      sec_cnt <= 16'h0000;
    end else if (sec_tick) begin
      sec_cnt <= sec_wrap ? 16'h0000 : sec_cnt + 16'h0001;
    end
  end

  // active secondary period: at once or at cycle boundary (primary unaffected)
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sec_period_act <= RST_PERIOD;
    end else if (f_imm_upd || sec_wrap || sync_rise || !module_enable) begin
      sec_period_act <= sec_period_buf;
    end
  end

  // compare matches on the tick taken while the count equals the compare value
  assign pri_match = pri_tick && (pri_cnt == sev_compare);
  assign sec_match = sec_tick && (sec_cnt == sev_compare);

  pmtb_postscaler u_pri_post (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (module_enable),
    .ratio_i   (f_post),
    .match_i   (pri_match),
    .trigger_o (special_event_trigger_o)
  );
  pmtb_postscaler u_sec_post (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (module_enable),
    .ratio_i   (f_post),
    .match_i   (sec_match),
    .trigger_o (sec_trigger)
  );

  // pending flag: set by event, cleared by hardware when the enable drops
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sev_pending <= 1'b0;
    end else if (sec_trigger && f_irq_en) begin
      sev_pending <= 1'b1;
    end else if (!f_irq_en || !module_enable) begin
      sev_pending <= 1'b0;
    end
  end

  assign secondary_irq_o = sev_pending && f_irq_en;

  // sync output: one-cycle pulse at the secondary boundary, polarity applied
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) secondary_sync_output_o <= 1'b0;
    else           secondary_sync_output_o <= (module_enable && sec_wrap) ^ f_sync_pol;
  end
  assign secondary_sync_output_oe_o = f_sync_oen;

  assign primary_master_timer_o   = pri_cnt;
  assign secondary_master_timer_o = sec_cnt;

  property p_irq_gated;
    @(posedge ref_clk_i) disable iff (sys_rst_i) secondary_irq_o |-> f_irq_en;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("request raised while disabled");
  property p_pending_sets;
    @(posedge ref_clk_i) disable iff (sys_rst_i) (sec_trigger && f_irq_en) |=> sev_pending;
  endproperty
  a_pending_sets: assert property (p_pending_sets) else $error("pending not set after event");
  property p_oe_follows;
    @(posedge ref_clk_i) disable iff (sys_rst_i) !f_sync_oen |-> !secondary_sync_output_oe_o;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("sync output driven while disabled");
  property p_sync_restart;
    @(posedge ref_clk_i) disable iff (sys_rst_i) sync_rise |=> (sec_cnt == 16'h0000);
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("sync edge did not restart counter");
  property p_imm_update;
    @(posedge ref_clk_i) disable iff (sys_rst_i) (f_imm_upd && $changed(sec_period_buf)) |=> (sec_period_act == sec_period_buf);
  endproperty
  a_imm_update: assert property (p_imm_update) else $error("immediate period not loaded");
  property p_cmp_low_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i) sev_compare[2:0] == 3'h0;
  endproperty
  a_cmp_low_zero: assert property (p_cmp_low_zero) else $error("compare low bits not zero");
  property p_pri_wrap;
    @(posedge ref_clk_i) disable iff (sys_rst_i) (module_enable && pri_tick && pri_cnt >= primary_period) |=> pri_cnt == 16'h0000;
  endproperty
  a_pri_wrap: assert property (p_pri_wrap) else $error("primary counter missed its wrap");
  property p_disabled_idle;
    @(posedge ref_clk_i) disable iff (sys_rst_i) !module_enable |=> (pri_cnt == 16'h0000 && sec_cnt == 16'h0000);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counters ran while disabled");

  c_sync_restart: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) sync_rise);
  c_irq_raised:   cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(secondary_irq_o));
  c_trigger:      cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) special_event_trigger_o);

endmodule

// ---- bench/tb_pwm_master_time_base_config.sv ----
// testbench: registers, prescalers, postscaler, sync and period loading of the time bases
`timescale 1ns/1ps
module tb_pwm_master_time_base_config;
  import pmtb_pkg::*;
  logic        clk   = 1'b0;  // 100 MHz system clock
  logic        rst   = 1'b1;  // synchronous reset
  logic [4:0]  addr  = 5'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  ext   = 4'h0;  // sync inputs, idle low
  logic        pol   = 1'b0;  // polarity in force, for the sync probe
  logic [31:0] rdata, q;
  logic        wreq, syo, syoe, trig, irq;
  logic [1:0]  resp;
  logic [15:0] pt, st, r;
  int          fails = 0, total_checks = 0, cyc = 0, n, k, seed = 34;
  localparam logic [15:0] RST_TBL [7] = '{16'h0000, 16'hFFF8, 16'h0000, 16'h0000, 16'h0000, 16'hFFF8, 16'h0000};
  localparam logic [3:0]  PS_TBL [3]  = '{4'h0, 4'h1, 4'hF};  // corner ratios 1:1, 1:2, 1:16

  always #5 clk = ~clk;

  pmtb_time_base i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .avs_response_o(resp), .external_sync_input_i(ext),
    .secondary_sync_output_o(syo), .secondary_sync_output_oe_o(syoe), .special_event_trigger_o(trig),
    .secondary_irq_o(irq), .primary_master_timer_o(pt), .secondary_master_timer_o(st));

  task final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task step(inout int g);
    @(negedge clk);
    g++;
  endtask

  // one avalon transfer; held until waitrequest is seen low, read data kept in q
  // only the global cycle ceiling ends a wait that never sees waitrequest low
  task bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= {16'h0000, d};
    do @(negedge clk); while (wreq !== 1'b0);
    @(posedge clk);
    q = rdata;
    if (!w) chk("resp", {30'h0, resp}, 32'h0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [15:0] ctl(input logic ie, im, pl, oe, xe, input logic [2:0] src, input logic [3:0] ps);
    return {4'h0, ie, im, pl, oe, xe, src, ps};
  endfunction

  function automatic logic probe(input int sel);  // active level of a pulse output
    return (sel == 0) ? trig : (syo ^ pol);
  endfunction

  // cycles between two successive changes of a live counter
  task tgap(input logic s, output int g);
    logic [15:0] v;
    @(negedge clk);
    v = s ? st : pt;
    g = 0;
    while ((s ? st : pt) === v && g < 200) step(g);
    v = s ? st : pt;
    g = 0;
    while ((s ? st : pt) === v && g < 200) step(g);
  endtask

  // cycles between two successive active pulses
  task pgap(input int sel, output int g);
    g = 0;
    do step(g); while (probe(sel) !== 1'b1 && g < 2000);
    g = 0;
    do step(g); while (probe(sel) !== 1'b1 && g < 2000);
  endtask

  // restart with the module off, so that new settings load at once
  task restart(input logic [15:0] c);
    bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
    bus(1'b1, OFF_SEC_CONTROL, c);
    bus(1'b1, OFF_MOD_ENABLE, 16'h0001);
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      final_report;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      bus(1'b0, 5'(k * 4), 16'h0000);
      chk("reset_value", q, {16'h0, RST_TBL[k]});
    end
    r = 16'($random(seed));
    bus(1'b1, OFF_SEV_COMPARE, r);
    bus(1'b0, OFF_SEV_COMPARE, 16'h0000);
    chk("compare_mask", q, {16'h0, r & MASK_COMPARE});
    bus(1'b1, OFF_SEC_CLK_DIV, 16'hFFFF);
    bus(1'b0, OFF_SEC_CLK_DIV, 16'h0000);
    chk("div_unimpl", q, 32'h7);
    // every prescale code 0..6 on both bases, opposite codes to catch swapped wiring
    for (k = 0; k < 7; k++) begin
      bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
      bus(1'b1, OFF_PRI_CLK_DIV, 16'(k));
      bus(1'b1, OFF_SEC_CLK_DIV, 16'(6 - k));
      bus(1'b1, OFF_MOD_ENABLE, 16'h0001);
      tgap(1'b0, n);
      chk("pri_tick", 32'(n), 32'(1 << k));
      tgap(1'b1, n);
      chk("sec_tick", 32'(n), 32'(1 << (6 - k)));
      bus(1'b1, OFF_PRI_CLK_DIV, 16'h0007);
      bus(1'b0, OFF_PRI_CLK_DIV, 16'h0000);
      chk("div_locked", q, 32'(k));
    end
    bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
    repeat (20) @(negedge clk);
    chk("halted", {16'h0, pt}, 32'h0);
    chk("halted_sec", {16'h0, st}, 32'h0);
    bus(1'b1, OFF_PRI_CLK_DIV, 16'h0000);
    bus(1'b1, OFF_SEC_CLK_DIV, 16'h0000);
    bus(1'b1, OFF_PRI_PERIOD, 16'h0010);
    bus(1'b1, OFF_SEC_PERIOD, 16'h0010);
    bus(1'b1, OFF_SEV_COMPARE, 16'h0008);
    // a period of 0x10 gives 17 counts a cycle, so one match every 17 clocks
    for (k = 0; k < 4; k++) begin
      r = (k < 3) ? {12'h0, PS_TBL[k]} : 16'($random(seed) & 32'hF);
      restart(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, r[3:0]));
      pgap(0, n);
      chk("trig_gap", 32'(n), 32'(17 * (r + 1)));
    end
    for (k = 0; k < 2; k++) begin
      pol = k[0];
      restart(ctl(1'b0, 1'b0, pol, 1'b1, 1'b0, 3'h0, 4'h0));
      pgap(1, n);
      chk("sync_gap", 32'(n), 32'd17);
      chk("sync_oe", {31'h0, syoe}, 32'h1);
    end
    restart(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0));
    chk("sync_oe_off", {31'h0, syoe}, 32'h0);
    repeat (40) @(negedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    restart(ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0));
    n = 0;
    while (irq !== 1'b1 && n < 100) step(n);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    bus(1'b0, OFF_SEC_CONTROL, 16'h0000);
    chk("pending_set", {31'h0, q[POS_SEV_PENDING]}, 32'h1);
    bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
    bus(1'b0, OFF_SEC_CONTROL, 16'h0000);
    chk("pending_clr", {31'h0, q[POS_SEV_PENDING]}, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    bus(1'b1, OFF_SEC_PERIOD, 16'hFFF8);
    // each source pin restarts the count; a wrong pin and a disabled sync do not
    for (k = 0; k < 5; k++) begin
      restart(ctl(1'b0, 1'b0, 1'b0, 1'b0, k < 4, 3'(k % 4), 4'h0));
      repeat (100) @(posedge clk);
      ext <= 4'(1 << ((k + 1) % 4));
      @(posedge clk);
      ext <= 4'h0;
      repeat (4) @(negedge clk);
      chk("wrong_pin", {31'h0, st > 16'd50}, 32'h1);
      @(posedge clk);
      ext <= 4'(1 << (k % 4));
      @(posedge clk);
      ext <= 4'h0;
      repeat (4) @(negedge clk);
      chk("sync_restart", {31'h0, st < 16'd8}, 32'(k < 4));
    end
    bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
    bus(1'b1, OFF_PRI_PERIOD, 16'hFFF8);
    for (k = 0; k < 2; k++) begin
      restart(ctl(1'b0, k == 0, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0));
      repeat (300) @(negedge clk);
      bus(1'b1, OFF_SEC_PERIOD, 16'h0040);
      bus(1'b1, OFF_PRI_PERIOD, 16'h0040);
      repeat (4) @(negedge clk);
      chk("sec_load", {31'h0, st < 16'h0041}, 32'(k == 0));
      // the primary period has no buffer: it takes the new value at once whatever the update bit says
      chk("pri_keep", {31'h0, pt < 16'h0041}, 32'h1);
      bus(1'b1, OFF_MOD_ENABLE, 16'h0000);
      bus(1'b1, OFF_SEC_PERIOD, 16'hFFF8);
      bus(1'b1, OFF_PRI_PERIOD, 16'hFFF8);
    end
    final_report;
  end
endmodule
